/* File: include/eeprom_pkg.sv */
// constants and types shared by the two-wire memory slave
package eeprom_pkg;

  localparam int                ADDR_W        = 15;
  localparam int                MEM_DEPTH     = 32768;
  localparam int                PAGE_W        = 6;
  localparam int                PAGE_BYTES    = 64;
  localparam int                STRAP_W       = 4;
  localparam logic [3:0]        DEV_CODE      = 4'hA;
  localparam logic [3:0]        BITS_PER_WORD = 4'h8;
  localparam logic [3:0]        FIRST_TX_BIT  = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_RESET    = 15'h0000;

  // program cycle: time in microseconds, clock period in nanoseconds
  localparam int PROG_TIME_US  = 5000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_CYCLES   = PROG_TIME_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b010,
    ST_TX   = 3'b011,
    ST_MACK = 3'b100
  } link_state_e;

  typedef enum logic [1:0] {
    RX_DEV  = 2'b00,
    RX_HI   = 2'b01,
    RX_LO   = 2'b10,
    RX_DATA = 2'b11
  } rx_kind_e;

endpackage

/* File: verilog/pin_sync.sv */
// pin synchronisers and start, stop and clock edge detection
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
  input  wire logic                          mclk,
  input  wire logic                          nrst,
  input  wire logic                          scl_pin,
  input  wire logic                          sda_pin,
  input  wire logic [eeprom_pkg::STRAP_W-1:0] strap_pins,
  output logic                               scl_s,
  output logic                               sda_s,
  output logic                               scl_rise,
  output logic                               scl_fall,
  output logic                               start_det,
  output logic                               stop_det,
  output logic [eeprom_pkg::STRAP_W-1:0]     strap_s
);

  logic                             scl_m_reg;
  logic                             sda_m_reg;
  logic [eeprom_pkg::STRAP_W-1:0]   strap_m_reg;
  logic                             scl_s_reg;
  logic                             sda_s_reg;
  logic [eeprom_pkg::STRAP_W-1:0]   strap_s_reg;
  logic                             scl_d_reg;
  logic                             sda_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // two flops per pin plus a delay flop on scl and sda; idle bus reads high
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      scl_m_reg   <= 1'h1;
      sda_m_reg   <= 1'h1;
      strap_m_reg <= 4'h0;
      scl_s_reg   <= 1'h1;
      sda_s_reg   <= 1'h1;
      strap_s_reg <= 4'h0;
      scl_d_reg   <= 1'h1;
      sda_d_reg   <= 1'h1;
    end else begin
      scl_m_reg   <= scl_pin;
      sda_m_reg   <= sda_pin;
      strap_m_reg <= strap_pins;
      scl_s_reg   <= scl_m_reg;
      sda_s_reg   <= sda_m_reg;
      strap_s_reg <= strap_m_reg;
      scl_d_reg   <= scl_s_reg;
      sda_d_reg   <= sda_s_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sda moving while scl stays high marks start or stop
  assign scl_s     = scl_s_reg;
  assign sda_s     = sda_s_reg;
  assign strap_s   = strap_s_reg;
  assign scl_rise  = scl_s_reg & ~scl_d_reg;
  assign scl_fall  = ~scl_s_reg & scl_d_reg;
  assign start_det = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
  assign stop_det  = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;

endmodule

`default_nettype wire

/* File: verilog/serial_eeprom_two_wire_slave.sv */
// two-wire serial slave of a 32K-byte nonvolatile memory
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_two_wire_slave #(
  parameter int PROG_CYCLES = eeprom_pkg::PROG_CYCLES
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic bus_select_bit2,
  input  wire logic bus_select_bit1,
  input  wire logic bus_select_bit0,
  input  wire logic store_lock,
  output logic      prog_busy
);

  localparam int AW = eeprom_pkg::ADDR_W;
  localparam int PW = eeprom_pkg::PAGE_W;

  logic                         scl_s;
  logic                         sda_s;
  logic                         scl_rise;
  logic                         scl_fall;
  logic                         start_det;
  logic                         stop_det;
  logic [eeprom_pkg::STRAP_W-1:0] strap_s;

  eeprom_pkg::link_state_e      state_reg;
  eeprom_pkg::rx_kind_e         kind_reg;
  logic [3:0]                   bit_cnt_reg;
  logic [7:0]                   shift_reg;
  logic [7:0]                   tx_reg;
  logic                         rd_dir_reg;
  logic                         mack_reg;
  logic                         sda_oe_reg;
  logic                         sda_out_reg;
  logic [AW-1:0]                addr_reg;
  logic                         busy_reg;
  logic [31:0]                  prog_cnt_reg;
  logic [AW-PW-1:0]             page_reg;
  logic [eeprom_pkg::PAGE_BYTES-1:0] valid_reg;
  logic [7:0]                   page_buf [eeprom_pkg::PAGE_BYTES];
  logic [7:0]                   mem [eeprom_pkg::MEM_DEPTH];

  logic                         byte_end;
  logic                         dev_ok;
  logic                         tx_load;
  logic                         data_done;
  logic [7:0]                   mem_rd;
  logic                         lock_s;
  logic [PW-1:0]                prog_idx;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic addr_match(input logic [7:0] word,
                                      input logic [2:0] sel);
    addr_match = (word[7:4] == eeprom_pkg::DEV_CODE) && (word[3:1] == sel);
  endfunction

  function automatic logic [AW-1:0] page_inc(input logic [AW-1:0] a);
    page_inc = {a[AW-1:PW], a[PW-1:0] + 6'h01};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and condition detection
  pin_sync u_sync (
    .mclk       (mclk),
    .nrst       (nrst),
    .scl_pin    (scl),
    .sda_pin    (sda_in),
    .strap_pins ({store_lock, bus_select_bit2, bus_select_bit1,
                  bus_select_bit0}),
    .scl_s      (scl_s),
    .sda_s      (sda_s),
    .scl_rise   (scl_rise),
    .scl_fall   (scl_fall),
    .start_det  (start_det),
    .stop_det   (stop_det),
    .strap_s    (strap_s)
  );

  assign lock_s    = strap_s[3];
  assign mem_rd    = mem[addr_reg];
  assign byte_end  = (state_reg == eeprom_pkg::ST_RX) && scl_fall &&
                     (bit_cnt_reg == eeprom_pkg::BITS_PER_WORD);
  assign dev_ok    = byte_end && (kind_reg == eeprom_pkg::RX_DEV) &&
                     addr_match(shift_reg, strap_s[2:0]) && !busy_reg;
  assign data_done = byte_end && (kind_reg == eeprom_pkg::RX_DATA);
  assign tx_load   = scl_fall &&
                     (((state_reg == eeprom_pkg::ST_ACK) &&
                       (kind_reg == eeprom_pkg::RX_DEV) && rd_dir_reg) ||
                      ((state_reg == eeprom_pkg::ST_MACK) && mack_reg));
  assign prog_idx  = prog_cnt_reg[PW-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // bus protocol state machine
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_reg   <= eeprom_pkg::ST_IDLE;
      kind_reg    <= eeprom_pkg::RX_DEV;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      tx_reg      <= 8'h00;
      rd_dir_reg  <= 1'h0;
      mack_reg    <= 1'h0;
      sda_oe_reg  <= 1'h0;
    end else if (start_det) begin
      state_reg   <= eeprom_pkg::ST_RX;
      kind_reg    <= eeprom_pkg::RX_DEV;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg  <= 1'h0;
    end else if (stop_det) begin
      state_reg   <= eeprom_pkg::ST_IDLE;
      sda_oe_reg  <= 1'h0;
    end else begin
      case (state_reg)
        eeprom_pkg::ST_IDLE: begin
          sda_oe_reg <= 1'h0;
        end
        eeprom_pkg::ST_RX: begin
          if (scl_rise && bit_cnt_reg != eeprom_pkg::BITS_PER_WORD) begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (byte_end) begin
            if (kind_reg != eeprom_pkg::RX_DEV || dev_ok) begin
              sda_oe_reg <= 1'h1;
              state_reg  <= eeprom_pkg::ST_ACK;
            end else begin
              state_reg  <= eeprom_pkg::ST_IDLE;
            end
            if (kind_reg == eeprom_pkg::RX_DEV) begin
              rd_dir_reg <= shift_reg[0];
            end
          end
        end
        eeprom_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (tx_load) begin
              tx_reg      <= mem_rd;
              sda_oe_reg  <= ~mem_rd[7];
              bit_cnt_reg <= eeprom_pkg::FIRST_TX_BIT;
              state_reg   <= eeprom_pkg::ST_TX;
            end else begin
              sda_oe_reg  <= 1'h0;
              bit_cnt_reg <= 4'h0;
              state_reg   <= eeprom_pkg::ST_RX;
              case (kind_reg)
                eeprom_pkg::RX_DEV: kind_reg <= eeprom_pkg::RX_HI;
                eeprom_pkg::RX_HI:  kind_reg <= eeprom_pkg::RX_LO;
                default:            kind_reg <= eeprom_pkg::RX_DATA;
              endcase
            end
          end
        end
        eeprom_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == eeprom_pkg::BITS_PER_WORD) begin
              sda_oe_reg <= 1'h0;
              mack_reg   <= 1'h0;
              state_reg  <= eeprom_pkg::ST_MACK;
            end else begin
              tx_reg      <= {tx_reg[6:0], 1'h0};
              sda_oe_reg  <= ~tx_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        eeprom_pkg::ST_MACK: begin
          if (scl_rise) begin
            mack_reg <= ~sda_s;
          end
          if (tx_load) begin
            tx_reg      <= mem_rd;
            sda_oe_reg  <= ~mem_rd[7];
            bit_cnt_reg <= eeprom_pkg::FIRST_TX_BIT;
            state_reg   <= eeprom_pkg::ST_TX;
          end else if (scl_fall) begin
            state_reg   <= eeprom_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg  <= eeprom_pkg::ST_IDLE;
          sda_oe_reg <= 1'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // internal address counter, kept across transactions
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      addr_reg <= eeprom_pkg::ADDR_RESET;
    end else if (byte_end && kind_reg == eeprom_pkg::RX_HI) begin
      addr_reg[AW-1:8] <= shift_reg[AW-9:0];
    end else if (byte_end && kind_reg == eeprom_pkg::RX_LO) begin
      addr_reg[7:0] <= shift_reg;
    end else if (data_done) begin
      addr_reg <= page_inc(addr_reg);
    end else if (tx_load) begin
      addr_reg <= addr_reg + 15'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // page buffer collects write data until the stop
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      valid_reg <= '0;
      page_reg  <= '0;
    end else if ((start_det || (stop_det && lock_s)) && !busy_reg) begin
      valid_reg <= '0;
    end else if (busy_reg && prog_cnt_reg == 32'(PROG_CYCLES - 1)) begin
      // used flags go, so no later stop can program them again
      valid_reg <= '0;
    end else if (data_done) begin
      page_buf[addr_reg[PW-1:0]]  <= shift_reg;
      valid_reg[addr_reg[PW-1:0]] <= 1'h1;
      page_reg                    <= addr_reg[AW-1:PW];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // self-timed program cycle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      busy_reg     <= 1'h0;
      prog_cnt_reg <= 32'h0000_0000;
    end else if (busy_reg) begin
      prog_cnt_reg <= prog_cnt_reg + 32'h0000_0001;
      if (prog_cnt_reg == 32'(PROG_CYCLES - 1)) begin
        busy_reg <= 1'h0;
      end
    end else if (stop_det && (|valid_reg) && !lock_s) begin
      busy_reg     <= 1'h1;
      prog_cnt_reg <= 32'h0000_0000;
    end
  end

  // the first page-size cycles copy flagged bytes into the array
  always_ff @(posedge mclk) begin
    if (busy_reg && prog_cnt_reg < 32'(eeprom_pkg::PAGE_BYTES) &&
        valid_reg[prog_idx]) begin
      mem[{page_reg, prog_idx}] <= page_buf[prog_idx];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sda_out_reg <= 1'h0;
    end else begin
      sda_out_reg <= 1'h0;
    end
  end

  assign sda_out   = sda_out_reg;
  assign sda_oe    = sda_oe_reg;
  assign prog_busy = busy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  a_drive_scl_low: assert property (
    $changed(sda_oe_reg) |-> !scl_s
  ) else $error("sda drive changed while scl high");

  a_start_restart: assert property (
    start_det |=> state_reg == eeprom_pkg::ST_RX && bit_cnt_reg == 4'h0 &&
                  kind_reg == eeprom_pkg::RX_DEV && !sda_oe_reg
  ) else $error("start did not restart address reception");

  a_stop_standby: assert property (
    stop_det && !start_det |=> state_reg == eeprom_pkg::ST_IDLE &&
                               !sda_oe_reg
  ) else $error("stop did not return to standby");

  a_word_ack: assert property (
    byte_end && kind_reg != eeprom_pkg::RX_DEV && !start_det && !stop_det
      |=> sda_oe_reg && state_reg == eeprom_pkg::ST_ACK
  ) else $error("received word not acknowledged");

  a_addr_mismatch: assert property (
    byte_end && kind_reg == eeprom_pkg::RX_DEV && !dev_ok
      |=> state_reg == eeprom_pkg::ST_IDLE && !sda_oe_reg
  ) else $error("mismatched address was acknowledged");

  a_busy_nack: assert property (
    busy_reg && byte_end && kind_reg == eeprom_pkg::RX_DEV |=> !sda_oe_reg
  ) else $error("address acknowledged during program cycle");

  a_page_wrap: assert property (
    data_done |=> addr_reg[AW-1:PW] == $past(addr_reg[AW-1:PW]) &&
                  addr_reg[PW-1:0] == $past(addr_reg[PW-1:0]) + 6'h01
  ) else $error("write address left its page");

  a_read_incr: assert property (
    tx_load |=> addr_reg == $past(addr_reg) + 15'h0001 &&
                tx_reg == $past(mem_rd)
  ) else $error("read did not advance the address counter");

  a_lock_skip: assert property (
    stop_det && lock_s && !busy_reg |=> !busy_reg
  ) else $error("program cycle started while locked");

  a_prog_length: assert property (
    $fell(busy_reg) |-> $past(prog_cnt_reg) == 32'(PROG_CYCLES - 1)
  ) else $error("program cycle ended at the wrong count");

  a_prog_start: assert property (
    stop_det && !busy_reg && (|valid_reg) && !lock_s
      |=> busy_reg && prog_cnt_reg == 32'h0000_0000
  ) else $error("write stop did not start the program cycle");

  c_write_prog: cover property ($rose(busy_reg));
  c_seq_read:   cover property (tx_load && state_reg == eeprom_pkg::ST_MACK);
  c_poll_nack:  cover property (busy_reg && byte_end &&
                                kind_reg == eeprom_pkg::RX_DEV);
  c_lock_stop:  cover property (stop_det && lock_s && (|valid_reg));

endmodule

`default_nettype wire

/* File: bench/bus_master_model.sv */
// behavioural two-wire bus master that drives clock and data for the bench
`timescale 1ns/1ps
`default_nettype none

module bus_master_model (
  input  wire logic       mclk,
  input  wire logic       sda_wire,
  output logic            scl,
  output logic            sda_drv,
  output logic            obs_valid,
  output logic [7:0]      obs_val
);
  initial begin
    scl       = 1'b1;
    sda_drv   = 1'b1;
    obs_valid = 1'b0;
    obs_val   = 8'h00;
  end

  task automatic ticks(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // one clock of the link; a sample may be posted as a result
  task automatic bit_io(input logic b, input logic post,
                        input logic [6:0] hi, output logic s);
    ticks(2);
    sda_drv = b;
    ticks(2);
    scl = 1'b1;
    ticks(3);
    s         = sda_wire;
    obs_val   = {hi, s};
    obs_valid = post;
    ticks(1);
    scl       = 1'b0;
    obs_valid = 1'b0;
  endtask

  // extra low tick lets a device ack release before clock goes high
  task automatic start_cond();
    ticks(2);
    sda_drv = 1'b1;
    ticks(3);
    scl = 1'b1;
    ticks(4);
    sda_drv = 1'b0;
    ticks(4);
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    ticks(2);
    sda_drv = 1'b0;
    ticks(2);
    scl = 1'b1;
    ticks(4);
    sda_drv = 1'b1;
    ticks(4);
  endtask

  // msb first, then the device's ack is posted as 00 or 01
  task automatic wr_byte(input logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], 1'b0, 7'h00, s);
    end
    bit_io(1'b1, 1'b1, 7'h00, s);
  endtask

  // eight bits in, whole byte posted, then master ack or nack
  task automatic rd_byte(input logic mack);
    logic [7:0] v;
    logic       s;
    v = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, i == 0, v[6:0], s);
      v = {v[6:0], s};
    end
    bit_io(mack, 1'b0, 7'h00, s);
  endtask

  task automatic sw_reset();
    logic s;
    start_cond();
    for (int i = 0; i < 9; i++) begin
      bit_io(1'b1, 1'b0, 7'h00, s);
    end
    start_cond();
    stop_cond();
  endtask
endmodule

`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench for the two-wire memory slave
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int PROG_CYC = 200;

  logic        mclk;
  logic        nrst;
  logic        scl;
  logic        sda_drv;
  logic        sda_wire;
  logic        sda_out;
  logic        sda_oe;
  logic [2:0]  sel;
  logic        store_lock;
  logic        prog_busy;
  logic        obs_valid;
  logic [7:0]  obs_val;
  logic [7:0]  exp_q[$];
  logic [7:0]  mem[0:32767];
  logic [31:0] lfsr;
  logic [14:0] base;
  logic [7:0]  d;
  int          err_total = 0;
  int          checks_done = 0;
  int          busy_len = 0;

  // open drain wire with pull-up
  assign sda_wire = sda_oe ? sda_out : sda_drv;

  serial_eeprom_two_wire_slave #(.PROG_CYCLES(PROG_CYC)) dut (
    .mclk            (mclk),
    .nrst            (nrst),
    .scl             (scl),
    .sda_in          (sda_wire),
    .sda_out         (sda_out),
    .sda_oe          (sda_oe),
    .bus_select_bit2 (sel[2]),
    .bus_select_bit1 (sel[1]),
    .bus_select_bit0 (sel[0]),
    .store_lock      (store_lock),
    .prog_busy       (prog_busy)
  );

  bus_master_model master (
    .mclk      (mclk),
    .sda_wire  (sda_wire),
    .scl       (scl),
    .sda_drv   (sda_drv),
    .obs_valid (obs_valid),
    .obs_val   (obs_val)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic fail(input string msg);
    err_total++;
    $display("[ERR] %0t %s", $time, msg);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction

  task automatic send(input logic [7:0] v, input logic [7:0] ack);
    exp_q.push_back(ack);
    master.wr_byte(v);
  endtask

  task automatic recv(input logic [7:0] e, input logic mack);
    exp_q.push_back(e);
    master.rd_byte(mack);
  endtask

  task automatic dev(input logic rw);
    master.start_cond();
    send({4'hA, sel, rw}, 8'h00);
  endtask

  // top bit of the high byte is always set: it must be ignored
  task automatic set_addr(input logic [14:0] a);
    dev(1'b0);
    send({1'b1, a[14:8]}, 8'h00);
    send(a[7:0], 8'h00);
  endtask

  task automatic write_run(input logic [14:0] a, input int n);
    set_addr(a);
    for (int i = 0; i < n; i++) begin
      d = rnd();
      mem[{a[14:6], 6'(a[5:0] + i)}] = d;
      send(d, 8'h00);
    end
    master.stop_cond();
  endtask

  task automatic wait_idle();
    repeat (3) @(negedge mclk);
    checks_done++;
    if (prog_busy !== 1'b1) fail("no program cycle after stop");
    master.start_cond();
    send({4'hA, sel, 1'b0}, 8'h01);
    master.stop_cond();
    for (int i = 0; i < 400 && prog_busy !== 1'b0; i++) @(negedge mclk);
    dev(1'b0);
    master.stop_cond();
  endtask

  task automatic read_run(input logic [14:0] a, input int n);
    set_addr(a);
    dev(1'b1);
    for (int i = 0; i < n; i++) begin
      recv(mem[15'(a + i)], i == n - 1);
    end
    master.stop_cond();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (obs_valid === 1'b1) begin
      checks_done++;
      if (exp_q.size() == 0) fail("unexpected result");
      else if (obs_val !== exp_q[0]) fail("result mismatch");
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end

  always @(negedge mclk) begin
    if (prog_busy === 1'b1) begin
      busy_len++;
    end else if (busy_len != 0) begin
      checks_done++;
      if (busy_len != PROG_CYC) fail("program cycle length");
      busy_len = 0;
    end
  end

  initial begin
    repeat (40000) @(posedge mclk);
    fail("watchdog expired");
    tally_and_finish();
  end

  initial begin
    nrst       = 1'b0;
    sel        = 3'h0;
    store_lock = 1'b0;
    lfsr       = 32'h0001_3F0E;
    repeat (4) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    checks_done++;
    if (prog_busy !== 1'b0 || sda_oe !== 1'b0) fail("not idle");
    d   = rnd();
    sel = d[2:0];
    master.start_cond();
    send({4'hA, ~sel, 1'b0}, 8'h01);
    master.stop_cond();
    d    = rnd();
    base = {d, 1'b0, 6'h3F};
    write_run(base, 66);
    wait_idle();
    read_run({base[14:6], 6'h00}, 63);
    dev(1'b1);
    recv(mem[{base[14:6], 6'h3F}], 1'b1);
    master.stop_cond();
    store_lock = 1'b1;
    set_addr(base);
    send(~mem[base], 8'h00);
    master.stop_cond();
    repeat (3) @(negedge mclk);
    checks_done++;
    if (prog_busy !== 1'b0) fail("busy while locked");
    store_lock = 1'b0;
    write_run(15'h7FFF, 1);
    wait_idle();
    write_run(15'h0000, 1);
    wait_idle();
    read_run(15'h7FFF, 2);
    set_addr(15'h0000);
    dev(1'b1);
    master.sw_reset();
    sel = ~sel;
    read_run(base, 1);
    repeat (20) @(negedge mclk);
    if (exp_q.size() != 0) fail("results missing");
    tally_and_finish();
  end
endmodule

`default_nettype wire
